// File: core/scs_map.vh
// Register offsets, field positions, codes and timing for the completion sequencer
`ifndef SCS_MAP_VH
`define SCS_MAP_VH
// Wishbone word offsets (byte addresses)
`define SCS_CMD_OFS 8'h00
`define SCS_INT_OFS 8'h04
`define SCS_PHASE_OFS 8'h08
`define SCS_EXMODE_OFS 8'h0C
`define SCS_EXSTAT_OFS 8'h10
`define SCS_FSTAT_OFS 8'h14
`define SCS_MSG_OFS 8'h18
`define SCS_RSTAT_OFS 8'h1C
`define SCS_TMO_OFS 8'h20
// Field positions
`define SCS_DEFER_BIT 0
`define SCS_EXTENDED_STATUS_REG_PAR_BIT 0
// Command codes
`define SCS_CMD_TGT 8'h31
`define SCS_CMD_INI_LO 6'h15
`define SCS_CMD_BREAK 8'h05
// Device states
`define SCS_ST_DISC 2'h0
`define SCS_ST_INIT 2'h1
`define SCS_ST_TGT 2'h2
// Interrupt codes
`define SCS_INT_NONE 8'h00
`define SCS_INT_DONE 8'h01
`define SCS_INT_INVAL 8'h02
`define SCS_INT_FIFO 8'h03
`define SCS_INT_OFFS 8'h04
`define SCS_INT_SPAR 8'h05
`define SCS_INT_CPAR 8'h06
`define SCS_INT_TMO 8'h07
`define SCS_INT_PHASE 8'h08
`define SCS_INT_RESET 8'h09
`define SCS_INT_DISC 8'h0A
`define SCS_INT_MSG 8'h0B
`define SCS_INT_BREAK 8'h0C
// Phase codes
`define SCS_PC_IDATA 8'h35
`define SCS_PC_ISTAT 8'h36
`define SCS_PC_IMSG 8'h37
`define SCS_PC_TSTAT 8'hA1
`define SCS_PC_TMSG 8'hA2
`define SCS_PC_TDISC 8'hA3
// Message and timing
`define SCS_MSG_CMD_DONE 8'h00
`define SCS_START_MAX 12
`define SCS_TMO_SHIFT 4
`define SCS_RESET_ST 8'h00
`endif

// File: core/scs_seq.v
// Composite completion sequencer: initiator and target completion commands
//
// Summary of operation
// - Immediate parity mode: parity error stops initiator command, interrupts, stays initiator.
// - Immediate parity mode: end-of-transfer flag held for DMA service after error.
// - Parity error in immediate mode asserts ATN automatically.
// - Deferred mode: finish phase, then check recorded parity error and interrupt.
// - Deferred error sets extended status bit, phase code keeps failing phase.
// - Initiator command outside initiator state gives invalid-command interrupt.
// - FIFO, offset, bus parity, CPU parity, timeout errors give distinct interrupts.
// - Phase change or unexpected phase gives phase-error interrupt.
// - Pending reset on initiator command: reset interrupt, then a further one.
// - Target bus release gives disconnected interrupt; if pending, invalid follows.
// - Received message other than command-complete gives message interrupt.
// - Initiator phase codes 35H data, 36H status, 37H message.
// - Code 31H is target completion: from target, ends disconnect or target.
// - Target status byte starts within twelve clocks of the command.
// - After status, one command-complete message byte in message-in phase.
// - After message, release bus, interrupt, enter disconnect state.
// - Break during target command stops, interrupts, stays target.
// - Abnormal target end (e.g. command parity) interrupts, stays target.
// - Handshake stall beyond programmed timeout signals timeout.
// - Target end phase codes A3H normal, A1H/A2H on ATN.
// - Pending reset on target command: reset interrupt, then invalid.
// - Received status byte stored before message reception starts.
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "scs_map.vh"

module scs_seq #(
  parameter TMO_W = 16
) (
  // Clock and reset
  input wire i_clk,
  input wire i_arst_n,
  // Wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  input wire i_cpu_par_err,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  // SCSI bus, active high levels
  input wire i_bsy,
  input wire i_rst,
  input wire i_req,
  input wire i_ack,
  input wire i_atn,
  input wire i_msg,
  input wire i_cd,
  input wire i_io,
  input wire [7:0] i_db,
  input wire i_db_par,
  output reg o_req,
  output reg o_ack,
  output reg o_atn,
  output reg o_bsy,
  output reg o_msg,
  output reg o_cd,
  output reg o_io,
  output reg [7:0] o_db,
  output reg o_db_par,
  output reg o_db_oe_n,
  // Host side events
  input wire i_fifo_err,
  input wire i_offset_err,
  input wire i_dma_svc,
  output reg o_xfer_end,
  output reg o_int
);

  ////////////////////////////////////////////////////////////////
  localparam S_IDLE = 3'd0;
  localparam S_IDATA = 3'd1;
  localparam S_ISTAT = 3'd2;
  localparam S_IMSG = 3'd3;
  localparam S_TSTAT = 3'd4;
  localparam S_TMSG = 3'd5;
  localparam S_HOLD = 3'd6;

  reg [2:0] seq_q;
  reg [1:0] dev_st_q;
  reg [7:0] int_q;
  reg [7:0] int_next_q;
  reg [7:0] phase_code_reg_q;
  reg [7:0] extended_mode_reg_q;
  reg [7:0] extended_status_reg_q;
  reg [7:0] final_status_reg_q;
  reg [7:0] msg_reg_q;
  reg [7:0] received_status_reg_q;
  reg [7:0] handshake_timeout_reg_q;
  reg [TMO_W-1:0] tmo_cnt_q;
  reg par_seen_q;
  reg rst_pend_q;
  reg disc_pend_q;
  reg hs_busy_q;

  wire parity_defer_enable = extended_mode_reg_q[`SCS_DEFER_BIT];
  wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire wb_wr = wb_req & i_wb_we & i_wb_sel[0];
  wire wb_rd = wb_req & ~i_wb_we;
  wire cmd_wr = wb_wr & (i_wb_adr == `SCS_CMD_OFS);
  wire [7:0] cmd = i_wb_dat[7:0];
  wire int_rd = wb_rd & (i_wb_adr == `SCS_INT_OFS);
  // Odd parity over byte plus parity bit
  wire par_bad = ~(^{i_db, i_db_par});
  wire in_data = ~i_msg & ~i_cd;
  wire in_stat = ~i_msg & i_cd & i_io;
  wire in_msgin = i_msg & i_cd & i_io;
  wire ini_busy = (seq_q == S_IDATA) | (seq_q == S_ISTAT) | (seq_q == S_IMSG);
  wire tgt_busy = (seq_q == S_TSTAT) | (seq_q == S_TMSG);
  wire ini_take = ini_busy & i_req & ~o_ack;
  wire tmo_hit = (tmo_cnt_q >> `SCS_TMO_SHIFT) > {{(TMO_W-8){1'b0}}, handshake_timeout_reg_q};
  // Any handshake edge restarts the count, so only a real stall times out
  wire hs_step = ini_take | (o_ack & ~i_req) | (o_req & i_ack) | (tgt_busy & ~o_req & ~i_ack);

  ////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, registered data
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end
    else
    begin
      o_wb_ack <= wb_req;
      o_wb_dat <= 32'h0000_0000;
      if (wb_rd)
      begin
        case (i_wb_adr)
          `SCS_CMD_OFS: o_wb_dat <= {24'h000000, 5'h00, seq_q != S_IDLE, dev_st_q};
          `SCS_INT_OFS: o_wb_dat <= {24'h000000, int_q};
          `SCS_PHASE_OFS: o_wb_dat <= {24'h000000, phase_code_reg_q};
          `SCS_EXMODE_OFS: o_wb_dat <= {24'h000000, extended_mode_reg_q};
          `SCS_EXSTAT_OFS: o_wb_dat <= {24'h000000, extended_status_reg_q};
          `SCS_FSTAT_OFS: o_wb_dat <= {24'h000000, final_status_reg_q};
          `SCS_MSG_OFS: o_wb_dat <= {24'h000000, msg_reg_q};
          `SCS_RSTAT_OFS: o_wb_dat <= {24'h000000, received_status_reg_q};
          `SCS_TMO_OFS: o_wb_dat <= {24'h000000, handshake_timeout_reg_q};
          default: o_wb_dat <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Plain configuration registers
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      extended_mode_reg_q <= `SCS_RESET_ST;
      final_status_reg_q <= `SCS_RESET_ST;
      handshake_timeout_reg_q <= 8'hFF;
    end
    else if (wb_wr)
    begin
      if (i_wb_adr == `SCS_EXMODE_OFS)
        extended_mode_reg_q <= i_wb_dat[7:0];
      if (i_wb_adr == `SCS_FSTAT_OFS)
        final_status_reg_q <= i_wb_dat[7:0];
      if (i_wb_adr == `SCS_TMO_OFS)
        handshake_timeout_reg_q <= i_wb_dat[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Pending bus conditions: reset seen at any time, disconnect seen while idle
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_pend_q <= 1'b0;
      disc_pend_q <= 1'b0;
    end
    else
    begin
      // Set wins over the clear a command write makes
      rst_pend_q <= i_rst | (rst_pend_q & ~cmd_wr);
      disc_pend_q <= (dev_st_q == `SCS_ST_INIT & ~i_bsy & seq_q == S_IDLE) | (disc_pend_q & ~cmd_wr);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Handshake stall timer
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      tmo_cnt_q <= {TMO_W{1'b0}};
    else if (!hs_busy_q | tmo_hit | hs_step)
      tmo_cnt_q <= {TMO_W{1'b0}};
    else
      tmo_cnt_q <= tmo_cnt_q + {{(TMO_W-1){1'b0}}, 1'b1};
  end

  ////////////////////////////////////////////////////////////////
  // Main sequencer
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      seq_q <= S_IDLE;
      dev_st_q <= `SCS_ST_DISC;
      int_q <= `SCS_INT_NONE;
      int_next_q <= `SCS_INT_NONE;
      phase_code_reg_q <= `SCS_RESET_ST;
      extended_status_reg_q <= `SCS_RESET_ST;
      msg_reg_q <= `SCS_RESET_ST;
      received_status_reg_q <= `SCS_RESET_ST;
      par_seen_q <= 1'b0;
      hs_busy_q <= 1'b0;
      o_int <= 1'b0;
      o_req <= 1'b0;
      o_ack <= 1'b0;
      o_atn <= 1'b0;
      o_bsy <= 1'b0;
      o_msg <= 1'b0;
      o_cd <= 1'b0;
      o_io <= 1'b0;
      o_db <= 8'h00;
      o_db_par <= 1'b0;
      o_db_oe_n <= 1'b1;
      o_xfer_end <= 1'b0;
    end
    else
    begin
      o_int <= (int_q != `SCS_INT_NONE);
      // Read of the interrupt code pops the queued follow-up
      if (int_rd)
      begin
        int_q <= int_next_q;
        int_next_q <= `SCS_INT_NONE;
      end
      // End flag held on DMA service after a parity error, in immediate parity mode only
      if (i_dma_svc & par_seen_q & ~parity_defer_enable)
        o_xfer_end <= 1'b1;
      else if (cmd_wr)
        o_xfer_end <= 1'b0;
      if (wb_wr & (i_wb_adr == `SCS_MSG_OFS))
        msg_reg_q <= i_wb_dat[7:0];
      if (cmd_wr & (cmd == `SCS_CMD_BREAK) & (seq_q != S_IDLE))
      begin
        seq_q <= S_IDLE;
        int_q <= `SCS_INT_BREAK;
        o_req <= 1'b0;
        o_ack <= 1'b0;
        o_db_oe_n <= 1'b1;
        hs_busy_q <= 1'b0;
      end
      else if (cmd_wr & (cmd[5:0] == `SCS_CMD_INI_LO) & (seq_q == S_IDLE))
      begin
        par_seen_q <= 1'b0;
        if (rst_pend_q)
        begin
          int_q <= `SCS_INT_RESET;
          int_next_q <= `SCS_INT_DONE;
        end
        else if (disc_pend_q)
        begin
          int_q <= `SCS_INT_DISC;
          int_next_q <= `SCS_INT_INVAL;
          dev_st_q <= `SCS_ST_DISC;
        end
        else if (dev_st_q != `SCS_ST_INIT)
          int_q <= `SCS_INT_INVAL;
        else if (i_cpu_par_err)
          int_q <= `SCS_INT_CPAR;
        else
        begin
          seq_q <= S_IDATA;
          phase_code_reg_q <= `SCS_PC_IDATA;
        end
      end
      else if (cmd_wr & (cmd == `SCS_CMD_TGT) & (seq_q == S_IDLE))
      begin
        if (rst_pend_q)
        begin
          int_q <= `SCS_INT_RESET;
          int_next_q <= `SCS_INT_INVAL;
          dev_st_q <= `SCS_ST_DISC;
        end
        else if (dev_st_q != `SCS_ST_TGT)
          int_q <= `SCS_INT_INVAL;
        else if (i_cpu_par_err)
          int_q <= `SCS_INT_CPAR;
        else
        begin
          seq_q <= S_TSTAT;
          phase_code_reg_q <= `SCS_PC_TSTAT;
          o_msg <= 1'b0;
          o_cd <= 1'b1;
          o_io <= 1'b1;
          o_db <= final_status_reg_q;
          o_db_par <= ~(^final_status_reg_q);
          o_db_oe_n <= 1'b0;
          o_req <= 1'b1;
          hs_busy_q <= 1'b1;
        end
      end
      else if (ini_busy & i_rst)
      begin
        seq_q <= S_IDLE;
        int_q <= `SCS_INT_RESET;
        dev_st_q <= `SCS_ST_DISC;
        o_ack <= 1'b0;
      end
      else if (ini_busy & ~i_bsy)
      begin
        seq_q <= S_IDLE;
        int_q <= `SCS_INT_DISC;
        dev_st_q <= `SCS_ST_DISC;
        o_ack <= 1'b0;
      end
      else if (ini_busy & (i_fifo_err | i_offset_err | tmo_hit))
      begin
        seq_q <= S_IDLE;
        int_q <= i_fifo_err ? `SCS_INT_FIFO : i_offset_err ? `SCS_INT_OFFS : `SCS_INT_TMO;
        hs_busy_q <= 1'b0;
      end
      else if (tgt_busy & tmo_hit)
      begin
        seq_q <= S_IDLE;
        int_q <= `SCS_INT_TMO;
        o_req <= 1'b0;
        o_db_oe_n <= 1'b1;
        hs_busy_q <= 1'b0;
      end
      else
      begin
        case (seq_q)
          S_IDATA:
          begin
            if (ini_take & in_data)
            begin
              o_ack <= 1'b1;
              if (par_bad)
              begin
                par_seen_q <= 1'b1;
                if (!parity_defer_enable)
                begin
                  o_atn <= 1'b1;
                  seq_q <= S_IDLE;
                  int_q <= `SCS_INT_SPAR;
                end
              end
            end
            else if (o_ack & ~i_req)
              o_ack <= 1'b0;
            else if (ini_take & in_stat)
            begin
              if (par_seen_q)
              begin
                seq_q <= S_IDLE;
                int_q <= `SCS_INT_SPAR;
                extended_status_reg_q[`SCS_EXTENDED_STATUS_REG_PAR_BIT] <= 1'b1;
              end
              else
              begin
                seq_q <= S_ISTAT;
                phase_code_reg_q <= `SCS_PC_ISTAT;
              end
            end
            else if (ini_take)
            begin
              seq_q <= S_IDLE;
              int_q <= `SCS_INT_PHASE;
            end
            hs_busy_q <= i_req | o_ack;
          end
          S_ISTAT:
          begin
            if (ini_take & ~in_stat)
            begin
              seq_q <= S_IDLE;
              int_q <= `SCS_INT_PHASE;
            end
            else if (ini_take)
            begin
              o_ack <= 1'b1;
              received_status_reg_q <= i_db;
              if (par_bad)
              begin
                par_seen_q <= 1'b1;
                o_atn <= ~parity_defer_enable;
                seq_q <= S_IDLE;
                int_q <= `SCS_INT_SPAR;
                extended_status_reg_q[`SCS_EXTENDED_STATUS_REG_PAR_BIT] <= parity_defer_enable;
              end
            end
            else if (o_ack & ~i_req)
            begin
              o_ack <= 1'b0;
              seq_q <= S_IMSG;
              phase_code_reg_q <= `SCS_PC_IMSG;
            end
            hs_busy_q <= 1'b1;
          end
          S_IMSG:
          begin
            if (ini_take & ~in_msgin)
            begin
              seq_q <= S_IDLE;
              int_q <= `SCS_INT_PHASE;
            end
            else if (ini_take)
            begin
              o_ack <= 1'b1;
              msg_reg_q <= i_db;
              if (par_bad)
              begin
                par_seen_q <= 1'b1;
                o_atn <= ~parity_defer_enable;
                seq_q <= S_IDLE;
                int_q <= `SCS_INT_SPAR;
                extended_status_reg_q[`SCS_EXTENDED_STATUS_REG_PAR_BIT] <= parity_defer_enable;
              end
              else if (i_db != `SCS_MSG_CMD_DONE)
              begin
                seq_q <= S_HOLD;
                int_q <= `SCS_INT_MSG;
              end
            end
            else if (o_ack & ~i_req)
            begin
              o_ack <= 1'b0;
              seq_q <= S_IDLE;
              int_q <= `SCS_INT_DONE;
              dev_st_q <= `SCS_ST_DISC;
            end
            hs_busy_q <= 1'b1;
          end
          S_HOLD:
          begin
            // Any new write to the command register releases ACK
            hs_busy_q <= 1'b0;
            if (cmd_wr)
            begin
              o_ack <= 1'b0;
              seq_q <= S_IDLE;
            end
          end
          S_TSTAT, S_TMSG:
          begin
            if (o_req & i_ack)
              o_req <= 1'b0;
            else if (~o_req & ~i_ack & i_atn)
            begin
              // ATN after a byte ends early
              seq_q <= S_IDLE;
              int_q <= `SCS_INT_DONE;
              o_db_oe_n <= 1'b1;
              hs_busy_q <= 1'b0;
            end
            else if (~o_req & ~i_ack & (seq_q == S_TSTAT))
            begin
              seq_q <= S_TMSG;
              phase_code_reg_q <= `SCS_PC_TMSG;
              o_msg <= 1'b1;
              o_db <= msg_reg_q;
              o_db_par <= ~(^msg_reg_q);
              o_req <= 1'b1;
            end
            else if (~o_req & ~i_ack)
            begin
              seq_q <= S_IDLE;
              phase_code_reg_q <= `SCS_PC_TDISC;
              int_q <= `SCS_INT_DONE;
              dev_st_q <= `SCS_ST_DISC;
              o_bsy <= 1'b0;
              o_msg <= 1'b0;
              o_cd <= 1'b0;
              o_io <= 1'b0;
              o_db_oe_n <= 1'b1;
              hs_busy_q <= 1'b0;
            end
          end
          default:
          begin
            hs_busy_q <= 1'b0;
            // Mode entry by software, stands in for selection commands
            if (wb_wr & (i_wb_adr == `SCS_CMD_OFS) & (cmd[7:6] == 2'b11))
            begin
              dev_st_q <= cmd[1:0];
              o_bsy <= (cmd[1:0] == `SCS_ST_TGT);
              o_atn <= 1'b0;
            end
          end
        endcase
      end
    end
  end

endmodule // scs_seq
`default_nettype wire

// File: dv/scs_seq_properties.sv
// Port-level assertions for the completion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "scs_map.vh"
module scs_seq_properties #(
  parameter TMO_W = 16
) (
  // Clock, reset and host side
  input wire logic i_clk, i_arst_n, i_wb_cyc, i_wb_stb, i_wb_we, i_cpu_par_err, o_wb_ack,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  // Bus lines and host events
  input wire logic i_rst, i_ack, i_dma_svc, o_req, o_atn, o_bsy, o_msg, o_cd, o_io, o_db_oe_n, o_xfer_end, o_int,
  input wire logic o_db_par,
  input wire logic [7:0] o_db
);
  //////////////////////////////////////////////////////////////////////////////
  // Command writes at the edge that takes them
  wire take = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_adr == `SCS_CMD_OFS;
  wire tgt_wr = take && i_wb_dat[7:0] == `SCS_CMD_TGT;
  wire brk_wr = take && i_wb_dat[7:0] == `SCS_CMD_BREAK;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  // Target state is visible as o_bsy driven
  a_status_start_bound: assert property (tgt_wr && o_bsy && !i_cpu_par_err && !i_rst |-> ##[1:12] o_req)
    else $error("status byte not started in time");
  a_req_release: assert property (o_req && i_ack |=> !o_req)
    else $error("request held after acknowledge");
  a_send_parity: assert property (o_req |-> ^{o_db, o_db_par})
    else $error("sent byte has even parity");
  a_send_phase: assert property (o_req |-> o_cd && o_io && !o_db_oe_n)
    else $error("target request outside status or message phase");
  a_bus_release: assert property ($fell(o_bsy) && $past(o_msg) |-> ##[0:1] (o_db_oe_n && !o_req && !o_cd) ##[0:4] o_int)
    else $error("bus not released with interrupt");
  a_end_hold: assert property ($rose(o_xfer_end) |-> $past(i_dma_svc))
    else $error("end of transfer without service cycle");
  a_atn_irq: assert property ($rose(o_atn) |-> ##[0:6] o_int)
    else $error("attention without interrupt");
  a_break_stop: assert property (brk_wr && o_cd && !o_db_oe_n |-> ##[1:6] o_int)
    else $error("break gave no interrupt");
  a_cmd_parity: assert property (tgt_wr && i_cpu_par_err |-> ##1 (!o_req)[*8])
    else $error("command with bad parity started");
  a_reset_pend: assert property (tgt_wr && i_rst |-> ##[1:6] o_int)
    else $error("pending reset gave no interrupt");
endmodule // scs_seq_properties
`default_nettype wire

// File: dv/scs_far.sv
// Behavioural far-end SCSI party: initiator for target runs, target for initiator runs
`timescale 1ns/1ps
`default_nettype none
module scs_far (
  // Clock and bench controls
  input wire logic i_clk, i_ack_en,
  input wire logic [1:0] i_atn_mode,
  input wire logic [3:0] i_dly,
  // Lines from the sequencer
  input wire logic i_req, i_ack, i_msg,
  input wire logic [7:0] i_db,
  // Lines towards the sequencer and captured bytes
  output logic o_ack, o_req, o_atn, o_msg, o_cd, o_io, o_db_par,
  output logic [7:0] o_db, o_st_cap, o_msg_cap
);
  logic [3:0] wait_q;
  //////////////////////////////////////////////////////////////////////////////
  // Idle lines; data shows a pattern, never a kept value
  initial
  begin
    {o_ack, o_req, o_atn, o_msg, o_cd, o_io, o_db_par} = 7'h0;
    {o_db, o_st_cap, o_msg_cap, wait_q} = 28'hC3FFFF0;
  end
  // Answer after i_dly waits, so slow initiators are covered too
  always @(posedge i_clk)
  begin
    if (i_atn_mode == 2'h0)
      o_atn <= 1'b0;
    if (!i_req)
      {o_ack, wait_q} <= 5'h0;
    else if (!o_ack && i_ack_en)
    begin
      wait_q <= wait_q + 4'h1;
      if (wait_q >= i_dly)
      begin
        o_ack <= 1'b1;
        o_msg_cap <= i_msg ? i_db : o_msg_cap;
        o_st_cap <= i_msg ? o_st_cap : i_db;
        o_atn <= o_atn || (i_atn_mode != 2'h0 && i_msg == (i_atn_mode == 2'h2));
      end
    end
  end
  // One target byte: hold request until ack, release, then scramble data
  task automatic send(input logic [2:0] ph, input logic [7:0] b, input logic bad);
    integer n;
    @(posedge i_clk);
    {o_msg, o_cd, o_io} <= ph;
    {o_db, o_db_par} <= {b, ~(^b) ^ bad};
    o_req <= 1'b1;
    for (n = 0; n < 40 && i_ack !== 1'b1; n++)
      @(posedge i_clk);
    o_req <= 1'b0;
    for (n = 0; n < 40 && i_ack !== 1'b0; n++)
      @(posedge i_clk);
    {o_db, o_db_par} <= {~b, (^b) ^ bad};
  endtask
endmodule // scs_far
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the completion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "scs_map.vh"
module testbench;
  logic i_clk, i_arst_n, i_wb_cyc, i_wb_stb, i_wb_we, i_cpu_par_err, i_bsy, i_rst, i_fifo_err, i_offset_err;
  logic i_dma_svc, ack_en;
  logic [1:0] atn_mode;
  logic [3:0] i_wb_sel, dly;
  logic [7:0] i_wb_adr;
  logic [31:0] i_wb_dat;
  wire [31:0] o_wb_dat;
  wire o_wb_ack, o_req, o_ack, o_atn, o_bsy, o_msg, o_cd, o_io, o_db_par, o_db_oe_n, o_xfer_end, o_int;
  wire i_req, i_ack, i_atn, i_msg, i_cd, i_io, i_db_par;
  wire [7:0] o_db, i_db, st_cap, msg_cap;
  integer n_mismatch = 0;
  integer n_checks = 0;
  integer cyc_cnt = 0;
  integer k;
  localparam logic [31:0] TCODES = {`SCS_INT_RESET, `SCS_INT_CPAR, `SCS_INT_TMO, `SCS_INT_BREAK};
  localparam logic [31:0] ICODES = {`SCS_INT_DISC, `SCS_INT_PHASE, `SCS_INT_OFFS, `SCS_INT_FIFO};
  //////////////////////////////////////////////////////////////////////////////
  scs_seq #(.TMO_W(16)) scs_seq_inst (.*);
  scs_far scs_far_inst (.i_clk(i_clk), .i_ack_en(ack_en), .i_atn_mode(atn_mode), .i_dly(dly), .i_req(o_req),
    .i_ack(o_ack), .i_msg(o_msg), .i_db(o_db), .o_ack(i_ack), .o_req(i_req), .o_atn(i_atn), .o_msg(i_msg),
    .o_cd(i_cd), .o_io(i_io), .o_db_par(i_db_par), .o_db(i_db), .o_st_cap(st_cap), .o_msg_cap(msg_cap));
  // Clock and hang guard; a hang counts as a mismatch
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 30000)
    begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic single cycle; request held until ack is sampled
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w, output logic [31:0] r);
    @(posedge i_clk);
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'h3, w, a, d};
    @(posedge i_clk);
    // Ends on o_wb_ack; only the bench's hang guard ends a wait that never sees it
    while (o_wb_ack !== 1'b1)
      @(posedge i_clk);
    r = o_wb_dat;
    {i_wb_cyc, i_wb_stb} <= 2'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb(a, {24'h0, d}, 1'b1, r);
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    wb(a, 32'h0, 1'b0, r);
    cmp(r, {24'h0, e});
  endtask
  task automatic irq(input logic [7:0] code);
    integer n;
    for (n = 0; n < 400 && o_int !== 1'b1; n++)
      @(posedge i_clk);
    chk(`SCS_INT_OFS, code);
  endtask
  // Reset held three cycles; far side back to prompt, no ATN
  task automatic rst_all();
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    {i_bsy, i_rst, i_fifo_err, i_offset_err, i_dma_svc, i_cpu_par_err, ack_en, atn_mode, dly} <= 13'h40;
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
  endtask
  task automatic ini_start(input logic defer);
    rst_all();
    i_bsy <= 1'b1;
    wr(`SCS_EXMODE_OFS, {7'h0, defer});
    wr(`SCS_CMD_OFS, 8'hC1);
    wr(`SCS_CMD_OFS, 8'h15);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {i_clk, i_arst_n, i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_wb_sel} = {45'h0, 4'hF};
    {i_bsy, i_rst, i_fifo_err, i_offset_err, i_dma_svc, i_cpu_par_err, ack_en, atn_mode, dly} = 13'h0;
    rst_all();
    chk(`SCS_TMO_OFS, 8'hFF);
    chk(`SCS_PHASE_OFS, `SCS_RESET_ST);
    chk(8'h40, 8'h00);
    wr(`SCS_CMD_OFS, 8'h15);
    irq(`SCS_INT_INVAL);
    // Target completion: plain, ATN after status, ATN after message
    for (k = 0; k < 3; k++)
    begin
      rst_all();
      {atn_mode, dly} <= {k[1:0], k[3:0] * 4'h7};
      wr(`SCS_CMD_OFS, 8'hC2);
      wr(`SCS_FSTAT_OFS, 8'h40 + k[7:0]);
      wr(`SCS_MSG_OFS, `SCS_MSG_CMD_DONE);
      wr(`SCS_CMD_OFS, `SCS_CMD_TGT);
      irq(`SCS_INT_DONE);
      chk(`SCS_PHASE_OFS, k == 0 ? `SCS_PC_TDISC : (k == 1 ? `SCS_PC_TSTAT : `SCS_PC_TMSG));
      chk(`SCS_CMD_OFS, {6'h0, k == 0 ? `SCS_ST_DISC : `SCS_ST_TGT});
      cmp(st_cap, 8'h40 + k[7:0]);
      if (k == 0)
        cmp(msg_cap, `SCS_MSG_CMD_DONE);
    end
    // Target aborts: break, timeout, command parity, pending reset
    for (k = 0; k < 4; k++)
    begin
      rst_all();
      ack_en <= 1'b0;
      wr(`SCS_TMO_OFS, k == 1 ? 8'h01 : 8'hFF);
      wr(`SCS_CMD_OFS, 8'hC2);
      {i_cpu_par_err, i_rst} <= {k == 2, k == 3};
      wr(`SCS_CMD_OFS, `SCS_CMD_TGT);
      i_cpu_par_err <= 1'b0;
      if (k == 0)
        wr(`SCS_CMD_OFS, `SCS_CMD_BREAK);
      irq(TCODES[8*k +: 8]);
      chk(k == 3 ? `SCS_INT_OFS : `SCS_CMD_OFS, k == 3 ? `SCS_INT_INVAL : {6'h0, `SCS_ST_TGT});
    end
    // Initiator completion with good and foreign message
    for (k = 0; k < 2; k++)
    begin
      ini_start(1'b0);
      chk(`SCS_PHASE_OFS, `SCS_PC_IDATA);
      scs_far_inst.send(3'b001, 8'h5A, 1'b0);
      scs_far_inst.send(3'b011, 8'h22 + k[7:0], 1'b0);
      chk(`SCS_RSTAT_OFS, 8'h22 + k[7:0]);
      chk(`SCS_PHASE_OFS, `SCS_PC_IMSG);
      scs_far_inst.send(3'b111, k == 0 ? `SCS_MSG_CMD_DONE : 8'h07, 1'b0);
      irq(k == 0 ? `SCS_INT_DONE : `SCS_INT_MSG);
      cmp({31'h0, o_ack}, k);
    end
    // Pending disconnect, then pending reset with the command still accepted
    for (k = 0; k < 2; k++)
    begin
      rst_all();
      {i_bsy, i_rst} <= {k == 1, k == 1};
      wr(`SCS_CMD_OFS, 8'hC1);
      wr(`SCS_CMD_OFS, 8'h15);
      irq(k ? `SCS_INT_RESET : `SCS_INT_DISC);
      chk(`SCS_INT_OFS, k ? `SCS_INT_DONE : `SCS_INT_INVAL);
    end
    // Immediate parity stop, ATN and held end of transfer
    ini_start(1'b0);
    scs_far_inst.send(3'b001, 8'h5A, 1'b1);
    irq(`SCS_INT_SPAR);
    cmp({31'h0, o_atn}, 32'h1);
    chk(`SCS_CMD_OFS, {6'h0, `SCS_ST_INIT});
    i_dma_svc <= 1'b1;
    @(posedge i_clk);
    i_dma_svc <= 1'b0;
    @(posedge i_clk);
    cmp({31'h0, o_xfer_end}, 32'h1);
    // Deferred parity runs on to the phase end; immediate status parity keeps the status phase code
    ini_start(1'b1);
    scs_far_inst.send(3'b001, 8'h5A, 1'b1);
    scs_far_inst.send(3'b001, 8'hA5, 1'b0);
    cmp({31'h0, o_int}, 32'h0);
    scs_far_inst.send(3'b011, 8'h00, 1'b0);
    irq(`SCS_INT_SPAR);
    chk(`SCS_EXSTAT_OFS, 8'h01);
    chk(`SCS_PHASE_OFS, `SCS_PC_IDATA);
    ini_start(1'b0);
    scs_far_inst.send(3'b011, 8'h02, 1'b1);
    irq(`SCS_INT_SPAR);
    chk(`SCS_PHASE_OFS, `SCS_PC_ISTAT);
    // Host FIFO, offset, phase and bus-loss faults
    for (k = 0; k < 4; k++)
    begin
      ini_start(1'b0);
      {i_fifo_err, i_offset_err, i_bsy} <= {k == 0, k == 1, k != 3};
      if (k == 2)
        scs_far_inst.send(3'b111, 8'h00, 1'b0);
      irq(ICODES[8*k +: 8]);
    end
    summarize();
  end
endmodule // testbench
bind scs_seq scs_seq_properties #(.TMO_W(TMO_W)) scs_seq_properties_inst (.*);
`default_nettype wire
